// [hw/pcnt_pkg.sv]
package pcnt_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ   = 40_000_000;
   localparam int GATE_MS  = 1000;
   localparam int GATE_CYC = GATE_MS * (CLK_HZ / 1000);

   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam int          AW          = 8;
   localparam logic [7:0]  A_CTRL      = 8'h00;
   localparam logic [7:0]  A_STATUS    = 8'h04;
   localparam logic [7:0]  A_ERRCODE   = 8'h08;
   localparam logic [7:0]  A_OUTSTATE  = 8'h0C;
   localparam logic [7:0]  A_ACC_LO    = 8'h10;
   localparam logic [7:0]  A_ACC_HI    = 8'h14;
   localparam logic [7:0]  A_PROBE_LO  = 8'h18;
   localparam logic [7:0]  A_PROBE_HI  = 8'h1C;
   localparam logic [7:0]  A_RATE_PP   = 8'h20;
   localparam logic [7:0]  A_RATE_CYC  = 8'h24;
   localparam logic [7:0]  A_IRQ_STAT  = 8'h28;
   localparam logic [7:0]  A_IRQ_CLR   = 8'h2C;
   localparam logic [7:0]  A_IRQ_EN    = 8'h30;
   localparam logic [7:0]  A_TBL_OFS   = 8'h34;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CB_EN  = 0;
   localparam int CB_RUN = 1;
   localparam int CB_RST = 2;
   localparam int CB_EXE = 3;
   localparam int CTRL_W = 4;

   localparam int IB_HP  = 0;
   localparam int IB_LP  = 1;
   localparam int IB_OF  = 2;
   localparam int IB_UF  = 3;
   localparam int IB_TP  = 4;
   localparam int IB_CFG = 5;
   localparam int IRQ_W  = 6;

   // -----------------------------------------------------------------
   // Reset values and codes
   // -----------------------------------------------------------------
   localparam logic [3:0]  CTRL_RST   = 4'h0;
   localparam logic [5:0]  IRQ_EN_RST = 6'h00;
   localparam logic [15:0] ERR_NONE   = 16'h0000;
   localparam logic [15:0] ERR_OVF    = 16'h0001;
   localparam logic [15:0] ERR_UNF    = 16'h0002;
   localparam logic [15:0] ERR_BUSY   = 16'h0003;
   localparam logic [15:0] ERR_LIMIT  = 16'h0004;

   typedef enum logic [0:0] {
      DIV_IDLE = 1'b0,
      DIV_RUN  = 1'b1
   } div_state_t;

endpackage

// [hw/pulse_counter_control_setup.sv]
`timescale 1ns/1ps
// Summary of operation
// - Enable rising loads initial count, clears status, zeroes both rates
// - Enable low: accumulator and hit flags held, done, error and code cleared, rates zero
// - Pulses are counted only while run is set
// - Reset clears outputs, accumulator, counter status and both rates
// - Reset overrides run
// - Done high while enabled, running and error free
// - Per-pulse rate and cyclic rate reported in units per second
// - Probe trigger captures the accumulator
// - Counter 0 only: 16-bit output state word, bit 0 physical
// - A detected error raises error and places its code
// - Setup starts on execute rising; enable must be low then
// - Execute falling clears all setup outputs
// - Setup loads initial count, overflow and underflow limits
// - Setup loads high and low preset values
// - Setup loads preset patterns, output mask and table offset
// - Setup done raised when the setup action succeeds
// - High preset reached: pattern passes the mask to outputs
module pulse_counter_control_setup
   import pcnt_pkg::*;
#(
   parameter int CNT_W      = 64,
   parameter int COUNTER_ID = 0,
   parameter int GATE_CYC_P = GATE_CYC,
   parameter int CLK_HZ_P   = CLK_HZ
)
(
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst,
   // Register port
   input  wire logic [AW-1:0]    i_addr,
   input  wire logic [31:0]      i_wdata,
   input  wire logic             i_wr,
   input  wire logic             i_rd,
   output logic      [31:0]      o_rdata,
   // Counter inputs
   input  wire logic             i_cnt_pulse,
   input  wire logic             i_cnt_down,
   input  wire logic             i_probe,
   // Setup values
   input  wire logic [CNT_W-1:0] i_initial_count,
   input  wire logic [CNT_W-1:0] i_overflow_limit,
   input  wire logic [CNT_W-1:0] i_underflow_limit,
   input  wire logic [CNT_W-1:0] i_high_preset,
   input  wire logic [CNT_W-1:0] i_low_preset,
   input  wire logic [31:0]      i_high_preset_output_pattern,
   input  wire logic [31:0]      i_low_preset_output_pattern,
   input  wire logic [7:0]       i_output_gate_mask,
   input  wire logic [7:0]       i_limit_table_start_offset,
   // Status outputs
   output logic                  o_done,
   output logic                  o_active,
   output logic                  o_error,
   output logic      [15:0]      o_error_code,
   output logic                  o_setup_done,
   output logic                  o_setup_error,
   output logic      [15:0]      o_setup_error_code,
   output logic      [15:0]      o_output_states,
   output logic                  o_irq
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (CNT_W < 2 || CNT_W > 64)
      $error("CNT_W must lie in 2..64");
   if (GATE_CYC_P < 2 || CLK_HZ_P < 2)
      $error("Gate and clock counts must be at least 2");

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic              ex_d;
      logic              en_d;
      logic              cfg_ok;
      logic [CNT_W-1:0]  init;
      logic [CNT_W-1:0]  ovf;
      logic [CNT_W-1:0]  unf;
      logic [CNT_W-1:0]  hp;
      logic [CNT_W-1:0]  lp;
      logic [15:0]       hp_pat;
      logic [15:0]       lp_pat;
      logic [7:0]        mask;
      logic [7:0]        ofs;
      logic [CNT_W-1:0]  acc;
      logic [CNT_W-1:0]  probe;
      logic              done;
      logic              active;
      logic              err;
      logic [15:0]       ecode;
      logic              sdone;
      logic              serr;
      logic [15:0]       secode;
      logic              hp_hit;
      logic              lp_hit;
      logic              of_hit;
      logic              uf_hit;
      logic [15:0]       outs;
      logic [IRQ_W-1:0]  irq_st;
      logic [IRQ_W-1:0]  irq_en;
      logic              irq;
      logic [31:0]       rdata;
      logic [31:0]       gate_cnt;
      logic [31:0]       gate_pls;
      logic [31:0]       cyc_rate;
      logic [31:0]       per_cnt;
      div_state_t        dstate;
      logic [31:0]       div_d;
      logic [31:0]       div_q;
      logic [31:0]       div_r;
      logic [5:0]        div_n;
      logic [31:0]       pp_rate;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // Signed widening so a short counter still reads as a 64-bit pair
   function automatic logic [31:0] word_of(input logic [CNT_W-1:0] v,
                                           input logic             hi);
      logic [63:0] x;
      x = 64'($signed(v));
      return hi ? x[63:32] : x[31:0];
   endfunction

   // Outputs masked through the gate: only masked bits change
   function automatic logic [15:0] gate_out(input logic [15:0] cur,
                                            input logic [15:0] pat,
                                            input logic [7:0]  msk);
      logic [15:0] m;
      m = {8'h00, msk};
      return (cur & ~m) | (pat & m);
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] clr;
      logic [CNT_W-1:0] nv;
      logic [31:0]      r2;
      logic             en;
      logic             run;
      logic             exe;
      ev    = '0;
      clr   = '0;
      nv    = '0;
      r2    = '0;
      st_nxt = st_r;
      en    = st_r.ctrl[CB_EN];
      run   = st_r.ctrl[CB_RUN];
      exe   = st_r.ctrl[CB_EXE];

      // -------------------------------------------------------------
      // Register writes
      // -------------------------------------------------------------
      if (i_wr)
      begin
         case (i_addr)
            A_CTRL:    st_nxt.ctrl   = i_wdata[CTRL_W-1:0];
            A_IRQ_CLR: clr           = i_wdata[IRQ_W-1:0];
            A_IRQ_EN:  st_nxt.irq_en = i_wdata[IRQ_W-1:0];
            default:   st_nxt.ctrl   = st_r.ctrl;
         endcase
      end

      // -------------------------------------------------------------
      // Setup
      // -------------------------------------------------------------
      st_nxt.ex_d = exe;
      if (exe && !st_r.ex_d)
      begin
         if (en)
         begin
            st_nxt.serr   = 1'b1;
            st_nxt.secode = ERR_BUSY;
         end
         else if ($signed(i_overflow_limit) <= $signed(i_underflow_limit)
                  || $signed(i_initial_count) > $signed(i_overflow_limit)
                  || $signed(i_initial_count) < $signed(i_underflow_limit))
         begin
            st_nxt.serr   = 1'b1;
            st_nxt.secode = ERR_LIMIT;
         end
         else
         begin
            st_nxt.init   = i_initial_count;
            st_nxt.ovf    = i_overflow_limit;
            st_nxt.unf    = i_underflow_limit;
            st_nxt.hp     = i_high_preset;
            st_nxt.lp     = i_low_preset;
            st_nxt.hp_pat = i_high_preset_output_pattern[15:0];
            st_nxt.lp_pat = i_low_preset_output_pattern[15:0];
            st_nxt.mask   = i_output_gate_mask;
            st_nxt.ofs    = i_limit_table_start_offset;
            st_nxt.cfg_ok = 1'b1;
            st_nxt.sdone  = 1'b1;
            ev[IB_CFG]    = 1'b1;
         end
      end
      else if (!exe && st_r.ex_d)
      begin
         // Held until here, then dropped
         st_nxt.sdone  = 1'b0;
         st_nxt.serr   = 1'b0;
         st_nxt.secode = ERR_NONE;
      end

      // -------------------------------------------------------------
      // Counter control
      // -------------------------------------------------------------
      st_nxt.en_d = en;
      if (st_r.ctrl[CB_RST])
      begin
         st_nxt.acc      = '0;
         st_nxt.probe    = '0;
         st_nxt.done     = 1'b0;
         st_nxt.active   = 1'b0;
         st_nxt.err      = 1'b0;
         st_nxt.ecode    = ERR_NONE;
         st_nxt.hp_hit   = 1'b0;
         st_nxt.lp_hit   = 1'b0;
         st_nxt.of_hit   = 1'b0;
         st_nxt.uf_hit   = 1'b0;
         st_nxt.outs     = '0;
      end
      else if (en && !st_r.en_d)
      begin
         st_nxt.acc      = st_r.init;
         st_nxt.err      = 1'b0;
         st_nxt.ecode    = ERR_NONE;
         st_nxt.hp_hit   = 1'b0;
         st_nxt.lp_hit   = 1'b0;
         st_nxt.of_hit   = 1'b0;
         st_nxt.uf_hit   = 1'b0;
      end
      else if (en)
      begin
         if (run && !st_r.err && i_cnt_pulse)
         begin
            nv = i_cnt_down ? st_r.acc - 1'b1 : st_r.acc + 1'b1;
            if (!i_cnt_down && $signed(st_r.acc) >= $signed(st_r.ovf))
            begin
               st_nxt.of_hit = 1'b1;
               st_nxt.err    = 1'b1;
               st_nxt.ecode  = ERR_OVF;
               ev[IB_OF]     = 1'b1;
            end
            else if (i_cnt_down
                     && $signed(st_r.acc) <= $signed(st_r.unf))
            begin
               st_nxt.uf_hit = 1'b1;
               st_nxt.err    = 1'b1;
               st_nxt.ecode  = ERR_UNF;
               ev[IB_UF]     = 1'b1;
            end
            else
            begin
               st_nxt.acc = nv;
               if (nv == st_r.hp)
               begin
                  st_nxt.hp_hit = 1'b1;
                  ev[IB_HP]     = 1'b1;
                  if (COUNTER_ID == 0)
                     st_nxt.outs = gate_out(st_r.outs, st_r.hp_pat,
                                            st_r.mask);
               end
               if (nv == st_r.lp)
               begin
                  st_nxt.lp_hit = 1'b1;
                  ev[IB_LP]     = 1'b1;
                  if (COUNTER_ID == 0)
                     st_nxt.outs = gate_out(st_r.outs, st_r.lp_pat,
                                            st_r.mask);
               end
            end
         end
         st_nxt.done   = run && !st_nxt.err;
         st_nxt.active = run && !st_nxt.err;
      end
      else
      begin
         st_nxt.done   = 1'b0;
         st_nxt.active = 1'b0;
         st_nxt.err    = 1'b0;
         st_nxt.ecode  = ERR_NONE;
      end

      if (i_probe && !st_r.ctrl[CB_RST])
      begin
         st_nxt.probe = st_nxt.acc;
         ev[IB_TP]    = 1'b1;
      end

      // -------------------------------------------------------------
      // Rates: cyclic counts pulses per gate, per-pulse divides
      // the clock rate by the pulse period
      // -------------------------------------------------------------
      if (st_r.ctrl[CB_RST] || !en || (en && !st_r.en_d) || !run)
      begin
         st_nxt.gate_cnt = '0;
         st_nxt.gate_pls = '0;
         st_nxt.cyc_rate = '0;
         st_nxt.per_cnt  = '0;
         st_nxt.pp_rate  = '0;
         st_nxt.dstate   = DIV_IDLE;
      end
      else
      begin
         if (st_r.gate_cnt == 32'(GATE_CYC_P - 1))
         begin
            st_nxt.cyc_rate = st_r.gate_pls + 32'(i_cnt_pulse);
            st_nxt.gate_cnt = '0;
            st_nxt.gate_pls = '0;
         end
         else
         begin
            st_nxt.gate_cnt = st_r.gate_cnt + 32'h00000001;
            st_nxt.gate_pls = st_r.gate_pls + 32'(i_cnt_pulse);
         end

         // Timed pulse to pulse only, so enable-to-first-pulse is no
         // period; saturates at one second, slower reads as zero
         if (st_r.per_cnt == 32'(CLK_HZ_P))
            st_nxt.pp_rate = '0;
         else if (st_r.per_cnt != '0)
            st_nxt.per_cnt = st_r.per_cnt + 32'h00000001;
         if (i_cnt_pulse)
         begin
            st_nxt.per_cnt = 32'h00000001;
            // A pulse during a division is dropped from the rate only
            if (st_r.per_cnt != '0 && st_r.per_cnt != 32'(CLK_HZ_P)
                && st_r.dstate == DIV_IDLE)
            begin
               st_nxt.div_d  = st_r.per_cnt;
               st_nxt.div_q  = 32'(CLK_HZ_P);
               st_nxt.div_r  = '0;
               st_nxt.div_n  = 6'h20;
               st_nxt.dstate = DIV_RUN;
            end
         end

         case (st_r.dstate)
            DIV_IDLE: st_nxt.div_n = st_nxt.div_n;
            DIV_RUN:
            begin
               r2 = {st_r.div_r[30:0], st_r.div_q[31]};
               if (r2 >= st_r.div_d)
               begin
                  st_nxt.div_r = r2 - st_r.div_d;
                  st_nxt.div_q = {st_r.div_q[30:0], 1'b1};
               end
               else
               begin
                  st_nxt.div_r = r2;
                  st_nxt.div_q = {st_r.div_q[30:0], 1'b0};
               end
               st_nxt.div_n = st_r.div_n - 6'h01;
               if (st_r.div_n == 6'h01)
               begin
                  st_nxt.pp_rate = st_nxt.div_q;
                  st_nxt.dstate  = DIV_IDLE;
               end
            end
            default: st_nxt.dstate = DIV_IDLE;
         endcase
      end

      // -------------------------------------------------------------
      // Interrupts: set wins over a clear in the same cycle
      // -------------------------------------------------------------
      st_nxt.irq_st = (st_r.irq_st & ~clr) | ev;
      st_nxt.irq    = |(st_nxt.irq_st & st_nxt.irq_en);

      // -------------------------------------------------------------
      // Register reads
      // -------------------------------------------------------------
      st_nxt.rdata = '0;
      if (i_rd)
      begin
         case (i_addr)
            A_CTRL:     st_nxt.rdata = 32'(st_r.ctrl);
            A_STATUS:   st_nxt.rdata = {20'h00000, en, run, st_r.cfg_ok,
                                        st_r.uf_hit, st_r.of_hit,
                                        st_r.lp_hit, st_r.hp_hit,
                                        st_r.serr, st_r.sdone, st_r.err,
                                        st_r.active, st_r.done};
            A_ERRCODE:  st_nxt.rdata = {st_r.secode, st_r.ecode};
            A_OUTSTATE: st_nxt.rdata = {16'h0000, st_r.outs};
            A_ACC_LO:   st_nxt.rdata = word_of(st_r.acc, 1'b0);
            A_ACC_HI:   st_nxt.rdata = word_of(st_r.acc, 1'b1);
            A_PROBE_LO: st_nxt.rdata = word_of(st_r.probe, 1'b0);
            A_PROBE_HI: st_nxt.rdata = word_of(st_r.probe, 1'b1);
            A_RATE_PP:  st_nxt.rdata = st_r.pp_rate;
            A_RATE_CYC: st_nxt.rdata = st_r.cyc_rate;
            A_IRQ_STAT: st_nxt.rdata = 32'(st_r.irq_st);
            A_IRQ_EN:   st_nxt.rdata = 32'(st_r.irq_en);
            A_TBL_OFS:  st_nxt.rdata = {24'h000000, st_r.ofs};
            default:    st_nxt.rdata = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         st_r        <= '0;
         st_r.ctrl   <= CTRL_RST;
         st_r.irq_en <= IRQ_EN_RST;
         st_r.dstate <= DIV_IDLE;
      end
      else
         st_r <= st_nxt;
   end

   assign o_rdata            = st_r.rdata;
   assign o_done             = st_r.done;
   assign o_active           = st_r.active;
   assign o_error            = st_r.err;
   assign o_error_code       = st_r.ecode;
   assign o_setup_done       = st_r.sdone;
   assign o_setup_error      = st_r.serr;
   assign o_setup_error_code = st_r.secode;
   assign o_output_states    = st_r.outs;
   assign o_irq              = st_r.irq;

endmodule

// [tb/pcnt_monitor.sv]
`timescale 1ns/1ps
module pcnt_monitor
   import pcnt_pkg::*;
(
   // Clock, reset and register port
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [31:0]   i_wdata,
   input  wire logic          i_wr,
   // Watched outputs
   input  wire logic          o_done,
   input  wire logic          o_active,
   input  wire logic          o_error,
   input  wire logic [15:0]   o_error_code,
   input  wire logic          o_setup_done,
   input  wire logic          o_setup_error,
   input  wire logic [15:0]   o_setup_error_code,
   input  wire logic [15:0]   o_output_states,
   input  wire logic          o_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   // ----
   // Control writes
   // ----
   wire cw = i_wr && (i_addr == A_CTRL);
   sequence exe_drop;
      cw ##0 !i_wdata[CB_EXE];
   endsequence
   sequence setup_idle;
      !o_setup_done && !o_setup_error;
   endsequence

   rst_clear_a: assert property (
      disable iff (1'b0) i_rst |=> !o_done && !o_error && !o_irq
      && !o_setup_done && o_output_states == 16'h0000)
      else $error("outputs not cleared by reset");
   done_act_a: assert property (o_done == o_active)
      else $error("done and active differ");
   done_err_a: assert property (o_done |-> !o_error)
      else $error("done while in error");
   err_code_a: assert property (
      o_error == (o_error_code != 16'h0000))
      else $error("error flag and code disagree");
   set_excl_a: assert property (
      !(o_setup_done && o_setup_error))
      else $error("setup done and error together");
   set_code_a: assert property (
      o_setup_error == (o_setup_error_code != 16'h0000))
      else $error("setup error flag and code disagree");
   // Enable-rise cycle delays done by one edge after the write
   done_rise_a: assert property (
      $rose(o_done) |-> $past(cw, 2) || $past(cw, 3))
      else $error("done rose without control write");
   set_rise_a: assert property (
      $rose(o_setup_done || o_setup_error) |-> $past(cw, 2))
      else $error("setup result without execute write");
   set_hold_a: assert property (
      o_setup_done && !$past(cw) |=> o_setup_done)
      else $error("setup done dropped early");
   set_clear_a: assert property (exe_drop |-> ##2 setup_idle)
      else $error("setup outputs kept after execute fell");
endmodule

bind pulse_counter_control_setup pcnt_monitor i_pcnt_monitor (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .o_done(o_done),
   .o_active(o_active), .o_error(o_error),
   .o_error_code(o_error_code), .o_setup_done(o_setup_done),
   .o_setup_error(o_setup_error),
   .o_setup_error_code(o_setup_error_code),
   .o_output_states(o_output_states), .o_irq(o_irq)
);

// [tb/pcnt_pulse_src.sv]
`timescale 1ns/1ps
module pcnt_pulse_src
(
   // Clock
   input  wire logic i_sys_clk,
   // Counter pins
   output logic      o_pulse = 1'b0,
   output logic      o_down = 1'b0,
   output logic      o_probe = 1'b0
);
   // Fixed ten-cycle spacing pins the per-pulse rate
   task automatic burst(input int n, input logic dn);
      repeat (n)
      begin
         @(posedge i_sys_clk);
         o_pulse <= 1'b1;
         o_down  <= dn;
         @(posedge i_sys_clk);
         o_pulse <= 1'b0;
         repeat (8) @(posedge i_sys_clk);
      end
   endtask
   task automatic touch();
      @(posedge i_sys_clk);
      o_probe <= 1'b1;
      @(posedge i_sys_clk);
      o_probe <= 1'b0;
   endtask
endmodule

// [tb/pulse_counter_control_setup_bench.sv]
`timescale 1ns/1ps
module pulse_counter_control_setup_bench;
   import pcnt_pkg::*;
   logic              clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [AW-1:0]     addr = '0;
   logic [31:0]       wdata = '0, rdata, v;
   logic [31:0]       hp_pat = 32'h0000_0003, lp_pat = 32'h0000_0004;
   logic [63:0]       init_c = 64'h5, of_l = 64'h14, hp = 64'h8;
   logic [63:0]       uf_l = 64'hFFFF_FFFF_FFFF_FFFB, lp = 64'h3;
   logic [7:0]        mask = 8'h0F, ofs = 8'h2A;
   logic              pulse, down, probe, done, act, err, s_done, s_err;
   logic              irq;
   logic [15:0]       code, s_code, outs;
   int                fails = 0, compares = 0, cyc = 0;
   always #12.5 clk = ~clk;

   pulse_counter_control_setup #(.GATE_CYC_P(100), .CLK_HZ_P(1000))
   i_pulse_counter_control_setup (
      .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cnt_pulse(pulse),
      .i_cnt_down(down), .i_probe(probe), .i_initial_count(init_c),
      .i_overflow_limit(of_l), .i_underflow_limit(uf_l),
      .i_high_preset(hp), .i_low_preset(lp),
      .i_high_preset_output_pattern(hp_pat),
      .i_low_preset_output_pattern(lp_pat), .i_output_gate_mask(mask),
      .i_limit_table_start_offset(ofs), .o_done(done), .o_active(act),
      .o_error(err), .o_error_code(code), .o_setup_done(s_done),
      .o_setup_error(s_err), .o_setup_error_code(s_code),
      .o_output_states(outs), .o_irq(irq));
   pcnt_pulse_src i_pcnt_pulse_src (.i_sys_clk(clk), .o_pulse(pulse),
      .o_down(down), .o_probe(probe));

   // ----
   // Register port tasks
   // ----
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
      chk(n, e, v);
   endtask
   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         give_verdict();
      end
   end

   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rchk("ctrl", A_CTRL, 32'h0);
      rchk("status", A_STATUS, 32'h0);
      rchk("irq_en", A_IRQ_EN, 32'h0);
      rchk("unmapped", 8'h3C, 32'h0);
      wr_reg(A_CTRL, 32'h1);
      wr_reg(A_CTRL, 32'h9);
      repeat (2) @(posedge clk);
      rchk("code_busy", A_ERRCODE, 32'h0003_0000);
      wr_reg(A_CTRL, 32'h0);
      of_l <= uf_l;
      repeat (3) @(posedge clk);
      chk("s_err_clr", 32'h0, 32'(s_err));
      wr_reg(A_CTRL, 32'h8);
      repeat (2) @(posedge clk);
      rchk("code_lim", A_ERRCODE, 32'h0004_0000);
      wr_reg(A_CTRL, 32'h0);
      of_l <= 64'h14;
      repeat (3) @(posedge clk);
      wr_reg(A_CTRL, 32'h8);
      repeat (2) @(posedge clk);
      chk("s_done", 32'h1, 32'(s_done));
      rchk("tbl_ofs", A_TBL_OFS, 32'h2A);
      rchk("irq_st", A_IRQ_STAT, 32'h20);
      wr_reg(A_IRQ_EN, 32'h20);
      repeat (2) @(posedge clk);
      chk("irq_on", 32'h1, 32'(irq));
      wr_reg(A_IRQ_CLR, 32'h20);
      repeat (2) @(posedge clk);
      chk("irq_off", 32'h0, 32'(irq));
      chk("s_hold", 32'h1, 32'(s_done));
      wr_reg(A_CTRL, 32'h0);
      repeat (3) @(posedge clk);
      chk("s_done_clr", 32'h0, 32'(s_done));
      wr_reg(A_CTRL, 32'h3);
      rchk("acc_init", A_ACC_LO, 32'h5);
      chk("done_run", 32'h1, 32'(done));
      i_pcnt_pulse_src.burst(3, 1'b0);
      rchk("acc_hp", A_ACC_LO, 32'h8);
      chk("outs_hp", 32'h3, 32'(outs));
      repeat (30) @(posedge clk);
      rchk("rate_pp", A_RATE_PP, 32'h64);
      i_pcnt_pulse_src.touch();
      rchk("probe", A_PROBE_LO, 32'h8);
      i_pcnt_pulse_src.burst(5, 1'b1);
      chk("outs_lp", 32'h4, 32'(outs));
      wr_reg(A_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk("done_stop", 32'h0, 32'(done));
      i_pcnt_pulse_src.burst(2, 1'b0);
      rchk("acc_stop", A_ACC_LO, 32'h3);
      wr_reg(A_CTRL, 32'h7);
      repeat (2) @(posedge clk);
      rchk("acc_rst", A_ACC_LO, 32'h0);
      rchk("rate_rst", A_RATE_PP, 32'h0);
      wr_reg(A_CTRL, 32'h0);
      wr_reg(A_CTRL, 32'h3);
      i_pcnt_pulse_src.burst(16, 1'b0);
      chk("ovf_code", 32'h1, 32'(code));
      rchk("acc_ovf", A_ACC_LO, 32'h14);
      rchk("rate_cyc_win", A_RATE_CYC, 32'hA);
      wr_reg(A_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      chk("err_off", 32'h0, 32'(err));
      chk("code_off", 32'h0, 32'(code));
      rchk("rate_cyc", A_RATE_CYC, 32'h0);
      wr_reg(A_CTRL, 32'h3);
      i_pcnt_pulse_src.burst(11, 1'b1);
      chk("unf_code", 32'h2, 32'(code));
      rchk("acc_unf", A_ACC_LO, 32'hFFFF_FFFB);
      give_verdict();
   end
endmodule
